//--- hdl/half_extend_add.sv
// Purpose: One 16-bit lane of the dual byte extend and add
// Assumes: Byte arrives already rotated into place
// Notes: Carry out of the lane is dropped
`timescale 1ns/1ps
`default_nettype none
module half_extend_add (
  input wire logic [7:0] byte_in,
  input wire logic [15:0] addend,
  input wire logic sign_ext,
  input wire logic add_en,
  output logic [15:0] lane_out
);
  logic [15:0] ext;
  always_comb begin
    ext = {{8{sign_ext & byte_in[7]}}, byte_in};
    lane_out = add_en ? 16'(ext + addend) : ext;
  end
endmodule
`default_nettype wire

//--- hdl/pack_extend_datapath.sv
// Purpose: Halfword pack, rotate and extend, and extend-add datapath
// Assumes: Decoder supplies operands read from the register file
// Notes: One registered result per issued operation, one cycle later
//        Flags pass straight through; no operation here alters them
//        Refused register use is flagged and nothing is written
// Overview of operation
// RL1 - Bottom-top pack puts first operand low half into result low half
// RL2 - Bottom-top pack puts shifted second operand high half into result high half
// RL3 - Top-bottom pack puts first operand high half into result high half
// RL4 - Top-bottom pack puts arithmetic-shifted second operand low half into result low
// RL5 - Bottom-top left shift is 1 to 31; zero means no shift
// RL6 - Top-bottom arithmetic right shift is 1 to 32; zero field means 32
// RL7 - Extends rotate the source right by 0, 8, 16 or 24 first
// RL8 - Signed byte extend replicates rotated bit 7 to 32 bits
// RL9 - Unsigned byte extend zero-fills above rotated bits 7 to 0
// RL10 - Signed half extend replicates rotated bit 15 into upper half
// RL11 - Unsigned half extend clears the upper half
// RL12 - Dual signed byte extend sign-extends rotated bytes 0 and 2 to halves
// RL13 - Dual unsigned byte extend zero-extends rotated bytes 0 and 2 to halves
// RL14 - Extend-add adds extended value to the full first operand
// RL15 - Dual extend-add adds each half independently, no carry between
// RL16 - Pack and extend operations leave the condition flags unchanged
// RL17 - Decoder never names stack pointer or program counter as pack destination
// RL18 - Decoder never names stack pointer or program counter as extend operand
// RL19 - Failed condition check writes nothing
// RL20 - Missing destination writes back to the register holding the extended value
`include "pack_extend_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pack_extend_datapath (
  input wire logic clk_sys,
  input wire logic rst,
  input wire pack_extend_pkg::px_issue_t issue,
  output pack_extend_pkg::px_result_t result
);

  logic [31:0] rotated;
  logic [31:0] shl_val;
  logic [31:0] asr_val;
  logic [5:0] asr_amt;
  logic [31:0] data_next;
  logic [31:0] extended;
  logic [15:0] lane_lo;
  logic [15:0] lane_hi;
  logic dual_signed;
  logic dual_add;
  logic dest_bad;
  logic rm_bad;
  logic rn_bad;
  logic [31:0] pack_bt_word;
  logic [31:0] pack_tb_word;
  logic [31:0] sbe_word;
  logic [31:0] ube_word;
  logic [31:0] she_word;
  logic [31:0] uhe_word;
  logic is_pack;
  logic is_extend;
  logic is_add;
  logic bad_reg;
  logic [3:0] reg_next;
  logic wen_next;
  pack_extend_pkg::px_result_t result_reg;
  pack_extend_pkg::px_result_t result_next;

  // RL7 rotate before extract
  always_comb begin
    case (issue.rotate_right_option)
      `PX_ROT_8: rotated = {issue.second_operand[7:0], issue.second_operand[31:8]};
      `PX_ROT_16: rotated = {issue.second_operand[15:0], issue.second_operand[31:16]};
      `PX_ROT_24: rotated = {issue.second_operand[23:0], issue.second_operand[31:24]};
      default: rotated = issue.second_operand;
    endcase
  end

  // RL5 left shift amount
  assign shl_val = issue.second_operand << issue.shift_amount;
  // RL6 zero field means 32
  always_comb begin
    if (issue.shift_amount == `PX_SHAMT_ZERO) begin
      asr_amt = `PX_ASR_FULL;
    end else begin
      asr_amt = {1'b0, issue.shift_amount};
    end
  end
  // RL4 shift keeps sign
  assign asr_val = $signed(issue.second_operand) >>> asr_amt;

  // Dual lane controls
  assign dual_signed = (issue.op == pack_extend_pkg::op_dual_signed_byte_extend) ||
                       (issue.op == pack_extend_pkg::op_dual_signed_byte_extend_add);
  assign dual_add = (issue.op == pack_extend_pkg::op_dual_signed_byte_extend_add) ||
                    (issue.op == pack_extend_pkg::op_dual_unsigned_byte_extend_add);

  // RL1 RL2 bottom-top pack
  assign pack_bt_word = {shl_val[31:16], issue.first_operand[15:0]};
  // RL3 RL4 top-bottom pack
  assign pack_tb_word = {issue.first_operand[31:16], asr_val[15:0]};

  // RL8 sign byte
  assign sbe_word = {{24{rotated[7]}}, rotated[7:0]};
  // RL9 zero byte
  assign ube_word = {`PX_FILL24_ZERO, rotated[7:0]};
  // RL10 sign half
  assign she_word = {{16{rotated[15]}}, rotated[15:0]};
  // RL11 zero half
  assign uhe_word = {`PX_FILL16_ZERO, rotated[15:0]};

  // RL12 low lane, RL13 and RL15 independent halves
  half_extend_add lane0 (
    .byte_in(rotated[7:0]),
    .addend(issue.first_operand[15:0]),
    .sign_ext(dual_signed),
    .add_en(dual_add),
    .lane_out(lane_lo)
  );
  // RL12 high lane from byte 2
  half_extend_add lane1 (
    .byte_in(rotated[23:16]),
    .addend(issue.first_operand[31:16]),
    .sign_ext(dual_signed),
    .add_en(dual_add),
    .lane_out(lane_hi)
  );

  always_comb begin
    extended = `PX_WORD_ZERO;
    is_pack = 1'b0;
    is_add = 1'b0;
    is_extend = 1'b1;
    data_next = `PX_WORD_ZERO;
    unique case (issue.op)
      pack_extend_pkg::op_pack_bottom_top: begin
        is_pack = 1'b1;
        is_extend = 1'b0;
        // RL1 RL2 select bottom-top
        data_next = pack_bt_word;
      end
      pack_extend_pkg::op_pack_top_bottom: begin
        is_pack = 1'b1;
        is_extend = 1'b0;
        // RL3 RL4 select top-bottom
        data_next = pack_tb_word;
      end
      pack_extend_pkg::op_signed_byte_extend, pack_extend_pkg::op_signed_byte_extend_add: begin
        // RL8 select sign byte
        extended = sbe_word;
        is_add = (issue.op == pack_extend_pkg::op_signed_byte_extend_add);
      end
      pack_extend_pkg::op_unsigned_byte_extend, pack_extend_pkg::op_unsigned_byte_extend_add: begin
        // RL9 select zero byte
        extended = ube_word;
        is_add = (issue.op == pack_extend_pkg::op_unsigned_byte_extend_add);
      end
      pack_extend_pkg::op_signed_half_extend, pack_extend_pkg::op_signed_half_extend_add: begin
        // RL10 select sign half
        extended = she_word;
        is_add = (issue.op == pack_extend_pkg::op_signed_half_extend_add);
      end
      pack_extend_pkg::op_unsigned_half_extend, pack_extend_pkg::op_unsigned_half_extend_add: begin
        // RL11 select zero half
        extended = uhe_word;
        is_add = (issue.op == pack_extend_pkg::op_unsigned_half_extend_add);
      end
      pack_extend_pkg::op_dual_signed_byte_extend, pack_extend_pkg::op_dual_unsigned_byte_extend,
      pack_extend_pkg::op_dual_signed_byte_extend_add, pack_extend_pkg::op_dual_unsigned_byte_extend_add: begin
        // RL12 RL13 lane results
        extended = {lane_hi, lane_lo};
      end
      default: begin
        // Nothing to write
        is_extend = 1'b0;
      end
    endcase
    if (is_extend) begin
      // RL14 full word add
      data_next = is_add ? 32'(extended + issue.first_operand) : extended;
    end
  end

  always_comb begin
    // RL20 default destination
    if (issue.dest_present) begin
      reg_next = issue.dest_reg;
    end else if (is_pack) begin
      reg_next = issue.first_operand_reg;
    end else begin
      reg_next = issue.second_operand_reg;
    end
    // RL17 destination check
    dest_bad = (reg_next == `PX_REG_SP) || (reg_next == `PX_REG_PC);
    // RL18 operand checks
    rm_bad = (issue.second_operand_reg == `PX_REG_SP) || (issue.second_operand_reg == `PX_REG_PC);
    rn_bad = (is_add || dual_add) &&
             ((issue.first_operand_reg == `PX_REG_SP) || (issue.first_operand_reg == `PX_REG_PC));
    bad_reg = 1'b0;
    if (is_pack) begin
      bad_reg = dest_bad;
    end else if (is_extend) begin
      bad_reg = dest_bad || rm_bad || rn_bad;
    end
    // RL19 condition gate
    wen_next = issue.valid && issue.cond_pass && (is_pack || is_extend) && !bad_reg;
    result_next.write_en = wen_next;
    result_next.write_reg = reg_next;
    // Data holds while nothing is written
    result_next.write_data = wen_next ? data_next : result_reg.write_data;
    // RL16 flags pass through
    result_next.flags_out = issue.flags_in;
    // RL17 RL18 refusal flag
    result_next.illegal_reg = issue.valid && bad_reg;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      result_reg <= '0;
    end else begin
      result_reg <= result_next;
    end
  end

  assign result = result_reg;

endmodule
`default_nettype wire

//--- hdl/pack_extend_pkg.sv
// Purpose: Types shared by the pack and extend datapath
// Assumes: Decoder drives one operation per issued cycle
// Notes: Operation codes are one-hot
package pack_extend_pkg;

  typedef enum logic [14:0] {
    op_none                       = 15'h0001,
    op_pack_bottom_top            = 15'h0002,
    op_pack_top_bottom            = 15'h0004,
    op_signed_byte_extend         = 15'h0008,
    op_unsigned_byte_extend       = 15'h0010,
    op_signed_half_extend         = 15'h0020,
    op_unsigned_half_extend       = 15'h0040,
    op_dual_signed_byte_extend    = 15'h0080,
    op_dual_unsigned_byte_extend  = 15'h0100,
    op_signed_byte_extend_add     = 15'h0200,
    op_unsigned_byte_extend_add   = 15'h0400,
    op_signed_half_extend_add     = 15'h0800,
    op_unsigned_half_extend_add   = 15'h1000,
    op_dual_signed_byte_extend_add   = 15'h2000,
    op_dual_unsigned_byte_extend_add = 15'h4000
  } px_op_t;

  typedef struct packed {
    logic valid;
    px_op_t op;
    logic cond_pass;
    logic dest_present;
    logic [3:0] dest_reg;
    logic [3:0] first_operand_reg;
    logic [3:0] second_operand_reg;
    logic [31:0] first_operand;
    logic [31:0] second_operand;
    logic [4:0] shift_amount;
    logic [1:0] rotate_right_option;
    logic [3:0] flags_in;
  } px_issue_t;

  typedef struct packed {
    logic write_en;
    logic [3:0] write_reg;
    logic [31:0] write_data;
    logic [3:0] flags_out;
    logic illegal_reg;
  } px_result_t;

endpackage

//--- hdl/pack_extend_regs.svh
// Purpose: Named constants for the pack and extend datapath
// Assumes: 32-bit operands, 4-bit register indices
// Notes: Shift and rotate codes as seen on the decoder port
`ifndef PACK_EXTEND_REGS_SVH
`define PACK_EXTEND_REGS_SVH

`define PX_WORD_W 32
`define PX_HALF_W 16
`define PX_REG_W 4
`define PX_SHAMT_W 5
`define PX_SHAMT_ZERO 5'h00
`define PX_ASR_FULL 6'h20
`define PX_ROT_0 2'h0
`define PX_ROT_8 2'h1
`define PX_ROT_16 2'h2
`define PX_ROT_24 2'h3
`define PX_REG_SP 4'hD
`define PX_REG_PC 4'hF
`define PX_WORD_ZERO 32'h0000_0000
`define PX_FILL24_ZERO 24'h00_0000
`define PX_FILL16_ZERO 16'h0000
`define PX_FLAGS_ZERO 4'h0

`endif

//--- verification/decoder_model.sv
// Purpose: Decoder and register file stand-in
// Assumes: Bench preloads registers
// Notes: Operands read by index, results written back
`timescale 1ns/1ps
`default_nettype none
module decoder_model (
  input wire logic clk_sys,
  input wire pack_extend_pkg::px_issue_t req,
  input wire pack_extend_pkg::px_result_t result,
  output var pack_extend_pkg::px_issue_t issue
);
  logic [31:0] regs [16];
  always_comb begin
    issue = req;
    issue.first_operand = regs[req.first_operand_reg];
    issue.second_operand = regs[req.second_operand_reg];
  end
  always @(posedge clk_sys) begin
    if (result.write_en) begin
      regs[result.write_reg] <= result.write_data;
    end
  end
endmodule
`default_nettype wire

//--- verification/pack_extend_datapath_assertions.sv
// Purpose: Port checks for the pack and extend datapath
// Assumes: One-hot op codes, result one cycle after issue
// Notes: Bound to the top module
`include "pack_extend_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pack_extend_datapath_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire pack_extend_pkg::px_issue_t issue,
  input wire pack_extend_pkg::px_result_t result
);
  logic [31:0] w;
  logic [14:0] o;
  logic we;
  logic z;
  logic sp_dest;
  assign sp_dest = issue.dest_present && (issue.dest_reg == `PX_REG_SP);
  assign w = result.write_data;
  assign o = issue.valid ? issue.op : 15'h0000;
  assign we = result.write_en;
  assign z = issue.shift_amount == `PX_SHAMT_ZERO;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_bt_low: assert property ($past(o[1]) && we |-> w[15:0] == $past(issue.first_operand[15:0]))
    else $error("pack low half wrong");
  a_bt_noshift: assert property ($past(o[1] && z) && we |-> w[31:16] == $past(issue.second_operand[31:16]))
    else $error("pack top half wrong");
  a_tb_full: assert property ($past(o[2] && z) && we |-> w[15:0] == {16{$past(issue.second_operand[31])}})
    else $error("pack full shift wrong");
  a_ube_zero: assert property ($past(o[4]) && we |-> w[31:8] == 24'h000000)
    else $error("byte zero fill wrong");
  a_sbe_sign: assert property ($past(o[3]) && we |-> w[31:8] == {24{w[7]}})
    else $error("byte sign fill wrong");
  a_flags_kept: assert property (!$past(rst) |-> result.flags_out == $past(issue.flags_in))
    else $error("flags changed");
  a_cond_quiet: assert property (issue.valid && !issue.cond_pass |=> !we)
    else $error("write on failed condition");
  a_dest_sp: assert property (o[1] && issue.cond_pass && sp_dest |=> result.illegal_reg && !we)
    else $error("stack pointer destination taken");
  a_uhe_zero: assert property ($past(o[6]) && we |-> w[31:16] == 16'h0000)
    else $error("half zero fill wrong");
  a_illegal_quiet: assert property (result.illegal_reg |-> !we)
    else $error("write on refused register");
  a_ext_dest: assert property ($past(o[10] && !issue.dest_present) && we |-> result.write_reg == $past(issue.second_operand_reg))
    else $error("default destination wrong");
  cover property ($past(o[13]) && we);
  cover property (result.illegal_reg);
  cover property ($past(o[2] && z) && we);
endmodule
bind pack_extend_datapath pack_extend_datapath_assertions u_chk (.clk_sys(clk_sys), .rst(rst), .issue(issue),
  .result(result));
`default_nettype wire

//--- verification/test_pack_extend_datapath.sv
// Purpose: Self-checking bench for the pack and extend datapath
// Assumes: Result one cycle after issue
// Notes: Inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module test_pack_extend_datapath;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  pack_extend_pkg::px_issue_t req = '0;
  pack_extend_pkg::px_issue_t issue;
  pack_extend_pkg::px_result_t result;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  always #2 clk_sys = ~clk_sys;
  decoder_model u_model (.clk_sys(clk_sys), .req(req), .result(result), .issue(issue));
  pack_extend_datapath dut (.clk_sys(clk_sys), .rst(rst), .issue(issue), .result(result));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic go(input int k, input logic [4:0] d, input logic [3:0] m, input logic [31:0] a,
                    input logic [31:0] x, input logic [4:0] s, input logic [1:0] r, input logic c);
    u_model.regs[1] = a;
    u_model.regs[m] = x;
    req = '{1'b1, pack_extend_pkg::px_op_t'(15'h0001 << k), c, d[4], d[3:0], 4'h1, m, 32'h0, 32'h0, s, r, a[3:0]};
    @(negedge clk_sys);
  endtask
  function automatic logic [31:0] ext(input int k, input logic [31:0] x, input logic [1:0] r, input logic [31:0] a);
    logic [63:0] t;
    logic [31:0] v;
    logic [31:0] e;
    t = {x, x} >> (8 * r);
    v = t[31:0];
    case (k > 8 ? k - 6 : k)
      3: e = {{24{v[7]}}, v[7:0]};
      4: e = {24'h000000, v[7:0]};
      5: e = {{16{v[15]}}, v[15:0]};
      6: e = {16'h0000, v[15:0]};
      7: e = {{8{v[23]}}, v[23:16], {8{v[7]}}, v[7:0]};
      default: e = {8'h00, v[23:16], 8'h00, v[7:0]};
    endcase
    if (k > 12) e = {e[31:16] + a[31:16], e[15:0] + a[15:0]};
    else if (k > 8) e = e + a;
    return e;
  endfunction
  task automatic t_pack();
    logic [4:0] sh [3] = '{5'h00, 5'h04, 5'h1F};
    logic [31:0] e;
    foreach (sh[i]) begin
      go(1, 5'h13, 4'h2, 32'hA5A5_1234, 32'h8001_C003, sh[i], 2'h0, 1'b1);
      chk("pack_bt", {16'(32'h8001_C003 << sh[i] >> 16), 16'h1234}, result.write_data);
      chk("flags", 32'h0000_0004, {28'h0, result.flags_out});
      e = $signed(32'h8001_C003) >>> (sh[i] == 5'h00 ? 6'h20 : {1'b0, sh[i]});
      go(2, 5'h13, 4'h2, 32'hA5A5_1234, 32'h8001_C003, sh[i], 2'h0, 1'b1);
      chk("pack_tb", {16'hA5A5, e[15:0]}, result.write_data);
    end
    go(1, 5'h00, 4'h2, 32'hA5A5_1234, 32'h8001_C003, 5'h00, 2'h0, 1'b1);
    chk("pack_reg", 32'h0000_0001, {28'h0, result.write_reg});
  endtask
  task automatic t_ext();
    for (int k = 3; k < 9; k++) begin
      for (int r = 0; r < 4; r++) begin
        go(k, 5'h13, 4'h2, 32'h0, 32'h80F7_7F01, 5'h00, 2'(r), 1'b1);
        chk("extend", ext(k, 32'h80F7_7F01, 2'(r), 32'h0), result.write_data);
      end
    end
  endtask
  task automatic t_add();
    for (int k = 9; k < 15; k++) begin
      go(k, 5'h00, 4'h2, 32'hFFFF_FFF0, 32'h0081_0090, 5'h00, 2'h0, 1'b1);
      chk("ext_add", ext(k, 32'h0081_0090, 2'h0, 32'hFFFF_FFF0), result.write_data);
      chk("ext_add_reg", 32'h0000_0002, {28'h0, result.write_reg});
    end
    req.valid = 1'b0;
    @(negedge clk_sys);
    chk("write_back", ext(14, 32'h0081_0090, 2'h0, 32'hFFFF_FFF0), u_model.regs[2]);
  endtask
  task automatic t_refuse();
    go(3, 5'h13, 4'h2, 32'h1, 32'h5, 5'h00, 2'h0, 1'b0);
    chk("cond_fail", 32'h0, {31'h0, result.write_en});
    go(1, 5'h1D, 4'h2, 32'h1, 32'h5, 5'h00, 2'h0, 1'b1);
    chk("sp_dest", 32'h1, {31'h0, result.illegal_reg & ~result.write_en});
    go(4, 5'h13, 4'hF, 32'h1, 32'h5, 5'h00, 2'h0, 1'b1);
    chk("pc_src", 32'h1, {31'h0, result.illegal_reg & ~result.write_en});
  endtask
  initial begin
    req.op = pack_extend_pkg::op_none;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    t_pack();
    t_ext();
    t_add();
    t_refuse();
    summarize();
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 500) begin
      bad_count++;
      summarize();
    end
  end
endmodule
`default_nettype wire
